// File: hw/cpr_ctrl_end.sv
`timescale 1ns/1ps
`default_nettype none
`include "cpr_cfg.svh"

// ==========================================================
// read data buffer
module cpr_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input  wire logic               clock,
  input  wire logic               rst_n,
  input  wire logic               in_valid,
  output logic                    in_ready,
  input  wire logic [W-1:0]       in_data,
  output logic                    out_valid,
  input  wire logic               out_ready,
  output logic [W-1:0]            out_data,
  output logic [$clog2(D):0]      count
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem [0:D-1];
  logic [AW:0]  wp_r;
  logic [AW:0]  rp_r;

  wire push = in_valid & in_ready;
  wire pop  = out_valid & out_ready;

  assign count     = wp_r - rp_r;
  assign in_ready  = (count != (AW+1)'(D));
  assign out_valid = (count != '0);
  assign out_data  = mem[rp_r[AW-1:0]];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      wp_r <= wp_r + (AW+1)'(push);
      rp_r <= rp_r + (AW+1)'(pop);
    end
  end

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wp_r[AW-1:0]] <= in_data;
    end
  end
endmodule : cpr_fifo

// ==========================================================
// controller end
module cpr_ctrl_end
  import cpr_pkg::*;
#(
  parameter int HALF         = `CPR_LINK_HALF_CYC,
  parameter int WL           = `CPR_WRITE_LAT,
  parameter int DLL_WAIT_NCK = `CPR_DLL_LOCK_NCK,
  parameter int GAP_NCK      = `CPR_GAP_NCK,
  parameter int FIFO_DEPTH   = 16
) (
  input  wire logic          clock,
  input  wire logic          rst_n,
  input  wire logic          dram_reset_req,
  input  wire logic          cmd_valid,
  output logic               cmd_ready,
  input  wire cpr_op_t       cmd_op,
  input  wire logic [2:0]    cmd_ba,
  input  wire logic [13:0]   cmd_addr,
  input  wire logic [63:0]   cmd_wdata,
  output logic               cmd_refused,
  output logic               pattern_mode,
  output logic               rd_valid,
  input  wire logic          rd_ready,
  output logic [7:0]         rd_data,
  cpr_if.ctrl                link
);
  localparam int FW = $clog2(FIFO_DEPTH) + 1;

  cpr_host_st_t st_r;
  logic [7:0]   div_r;
  logic         ck_r;
  logic         pin_n_r;
  logic [15:0]  dll_cnt_r;
  logic [15:0]  cnt_r;
  logic [3:0]   beat_r;
  logic [63:0]  wdata_r;
  logic         mode_r;
  logic [1:0]   bl_r;
  logic         cs_n_r;
  logic [2:0]   rcw_r;
  logic [2:0]   ba_r;
  logic [13:0]  addr_r;
  logic [7:0]   dq_r;
  logic         oe_r;
  logic         dqs_s1_r;
  logic         dqs_s2_r;
  logic         dqs_s3_r;
  logic [7:0]   dq_s1_r;
  logic [7:0]   dq_s2_r;
  logic [FW-1:0] level;
  logic         f_in_ready;

  // ==========================================================
  // link clock divider
  wire div_end  = (div_r == 8'(HALF - 1));
  wire fall_pt  = div_end & ck_r;
  wire rise_pt  = div_end & ~ck_r;
  wire quarter  = (div_r == 8'(HALF / 2 - 1));
  wire dll_ok   = (dll_cnt_r == 16'(DLL_WAIT_NCK));

  // ==========================================================
  // command admission
  wire is_rd    = (cmd_op == CPR_OP_RD);
  wire is_mrs   = (cmd_op == CPR_OP_MRS);
  wire mr3_wr   = is_mrs & (cmd_ba == `CPR_MR_SEL_THREE);
  wire room     = (level <= FW'(FIFO_DEPTH - 8)) & f_in_ready;
  wire stall    = is_rd & ~(dll_ok & room);
  // in pattern mode only reads and mode register 3 writes go out
  wire refuse   = ~is_rd & mode_r & ~mr3_wr;
  wire take     = cmd_valid & cmd_ready;
  wire issue    = take & ~refuse;
  wire chop     = (bl_r == `CPR_BL_FIXED4) |
                  ((bl_r == `CPR_BL_OTF) & ~cmd_addr[`CPR_CHOP_BIT]);
  wire [2:0] a_lo = chop ? {cmd_addr[2], 2'h0} : 3'h0;
  wire [13:0] out_addr = (is_rd & mode_r) ? {cmd_addr[13:3], a_lo} : cmd_addr;
  // a plain no-operation goes out as the no-operation code, never as a write
  wire [2:0] rcw_n = is_mrs ? 3'h0 : (is_rd ? 3'h5 : ((cmd_op == CPR_OP_WR) ? 3'h4 : 3'h7));

  assign cmd_ready    = (st_r == CPR_H_IDLE) & fall_pt & ~stall & pin_n_r;
  assign cmd_refused  = take & refuse;
  assign pattern_mode = mode_r;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      div_r     <= 8'h00;
      ck_r      <= 1'b0;
      pin_n_r   <= 1'b0;
      dll_cnt_r <= 16'h0000;
    end else begin
      div_r     <= div_end ? 8'h00 : (div_r + 8'h01);
      ck_r      <= div_end ? ~ck_r : ck_r;
      pin_n_r   <= ~dram_reset_req;
      if (!pin_n_r) begin
        dll_cnt_r <= 16'h0000;
      end else if (rise_pt && !dll_ok) begin
        dll_cnt_r <= dll_cnt_r + 16'h0001;
      end
    end
  end

  // ==========================================================
  // command pins, held for one link period
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cs_n_r <= 1'b1;
      rcw_r  <= 3'h7;
      ba_r   <= 3'h0;
      addr_r <= 14'h0000;
      mode_r <= 1'b0;
      bl_r   <= `CPR_BL_FIXED8;
    end else if (!pin_n_r) begin
      cs_n_r <= 1'b1;
      mode_r <= 1'b0;
      bl_r   <= `CPR_BL_FIXED8;
    end else if (fall_pt) begin
      cs_n_r <= ~issue;
      rcw_r  <= issue ? rcw_n : 3'h7;
      ba_r   <= cmd_ba;
      addr_r <= out_addr;
      // no bank is ever opened here, so all banks stay idle
      if (issue && mr3_wr) begin
        mode_r <= cmd_addr[`CPR_MR3_EN_BIT];
      end
      if (issue && is_mrs && cmd_ba == `CPR_MR_SEL_ZERO) begin
        bl_r <= cmd_addr[1:0];
      end
    end
  end

  // ==========================================================
  // sequencer: write latency, write beats, spacing
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r    <= CPR_H_IDLE;
      cnt_r   <= 16'h0000;
      beat_r  <= 4'h0;
      wdata_r <= 64'h0000_0000_0000_0000;
      dq_r    <= 8'h00;
      oe_r    <= 1'b0;
    end else begin
      case (st_r)
        CPR_H_IDLE: begin
          if (issue) begin
            st_r    <= (cmd_op == CPR_OP_WR) ? CPR_H_WLAT : CPR_H_GAP;
            cnt_r   <= 16'h0000;
            beat_r  <= 4'h0;
            wdata_r <= cmd_wdata;
          end
        end
        CPR_H_WLAT: begin
          if (rise_pt) begin
            cnt_r <= cnt_r + 16'h0001;
            if (cnt_r == 16'(WL)) begin
              st_r <= CPR_H_WDAT;
            end
          end
        end
        CPR_H_WDAT: begin
          if (quarter) begin
            oe_r   <= (beat_r != 4'h8);
            dq_r   <= wdata_r[8*beat_r[2:0] +: 8];
            beat_r <= beat_r + 4'h1;
            if (beat_r == 4'h8) begin
              st_r  <= CPR_H_GAP;
              cnt_r <= 16'h0000;
            end
          end
        end
        CPR_H_GAP: begin
          if (rise_pt) begin
            cnt_r <= cnt_r + 16'h0001;
            if (cnt_r == 16'(GAP_NCK - 1)) begin
              st_r <= CPR_H_IDLE;
            end
          end
        end
        default: st_r <= CPR_H_IDLE;
      endcase
    end
  end

  // ==========================================================
  // read capture on strobe edges
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dqs_s1_r <= 1'b0;
      dqs_s2_r <= 1'b0;
      dqs_s3_r <= 1'b0;
      dq_s1_r  <= 8'h00;
      dq_s2_r  <= 8'h00;
    end else begin
      dqs_s1_r <= link.dqs;
      dqs_s2_r <= dqs_s1_r;
      dqs_s3_r <= dqs_s2_r;
      dq_s1_r  <= link.dq;
      dq_s2_r  <= dq_s1_r;
    end
  end

  // reserved-location data is passed on as-is
  cpr_fifo #(.W(8), .D(FIFO_DEPTH)) i_cpr_fifo (
    .clock     (clock),
    .rst_n     (rst_n),
    .in_valid  (dqs_s2_r ^ dqs_s3_r),
    .in_ready  (f_in_ready),
    .in_data   (dq_s2_r),
    .out_valid (rd_valid),
    .out_ready (rd_ready),
    .out_data  (rd_data),
    .count     (level)
  );

  assign link.ck         = ck_r;
  assign link.rst_pin_n  = pin_n_r;
  assign link.cs_n       = cs_n_r;
  assign link.rcw_n      = rcw_r;
  assign link.ba         = ba_r;
  assign link.addr       = addr_r;
  assign link.host_dq_o  = dq_r;
  assign link.host_dq_oe = oe_r;

endmodule : cpr_ctrl_end

`default_nettype wire

// File: hw/cpr_cfg.svh
`ifndef CPR_CFG_SVH
`define CPR_CFG_SVH

// ==========================================================
// clock and link timing
`define CPR_CLK_PERIOD_NS   8
`define CPR_LINK_PERIOD_NS  160
`define CPR_LINK_HALF_CYC   ((`CPR_LINK_PERIOD_NS) / (2 * `CPR_CLK_PERIOD_NS))
`define CPR_READ_LAT        5
`define CPR_WRITE_LAT       5
`define CPR_DLL_LOCK_NCK    512
`define CPR_GAP_NCK         16

// ==========================================================
// mode register selects and field positions
`define CPR_MR_SEL_ZERO     3'h0
`define CPR_MR_SEL_THREE    3'h3
`define CPR_MR3_EN_BIT      2
`define CPR_CHOP_BIT        12
`define CPR_AP_BIT          10
`define CPR_BL_FIXED8       2'h0
`define CPR_BL_OTF          2'h1
`define CPR_BL_FIXED4       2'h2

// ==========================================================
// pattern words, beat 0 in bit 0
`define CPR_PATTERN_LOC0    8'hAA
`define CPR_PATTERN_RSVD    8'h00

`endif

// File: hw/cpr_pkg.sv
`default_nettype none

package cpr_pkg;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    CPR_OP_NOP = 2'h0,
    CPR_OP_MRS = 2'h1,
    CPR_OP_RD  = 2'h2,
    CPR_OP_WR  = 2'h3
  } cpr_op_t;

  typedef enum logic [1:0] {
    CPR_D_IDLE  = 2'h0,
    CPR_D_LAT   = 2'h1,
    CPR_D_BURST = 2'h2
  } cpr_dev_st_t;

  typedef enum logic [1:0] {
    CPR_H_IDLE = 2'h0,
    CPR_H_WLAT = 2'h1,
    CPR_H_WDAT = 2'h2,
    CPR_H_GAP  = 2'h3
  } cpr_host_st_t;

  function automatic cpr_op_t cpr_decode(input logic       cs_n,
                                         input logic [2:0] rcw_n);
    cpr_op_t op;
    op = CPR_OP_NOP;
    if (!cs_n) begin
      case (rcw_n)
        3'h0:    op = CPR_OP_MRS;
        3'h5:    op = CPR_OP_RD;
        3'h4:    op = CPR_OP_WR;
        default: op = CPR_OP_NOP;
      endcase
    end
    return op;
  endfunction : cpr_decode

endpackage : cpr_pkg

`default_nettype wire

// File: hw/cpr_if.sv
`timescale 1ns/1ps
`default_nettype none

interface cpr_if;
  logic        ck;
  logic        rst_pin_n;
  logic        cs_n;
  logic [2:0]  rcw_n;
  logic [2:0]  ba;
  logic [13:0] addr;
  logic        dqs;
  logic [7:0]  dev_dq_o;
  logic        dev_dq_oe;
  logic [7:0]  host_dq_o;
  logic        host_dq_oe;
  logic [7:0]  dq;

  // shared data wire, undriven reads as zero
  assign dq = dev_dq_oe ? dev_dq_o : (host_dq_oe ? host_dq_o : 8'h00);

  modport dram (input ck, rst_pin_n, cs_n, rcw_n, ba, addr, dq,
                output dev_dq_o, dev_dq_oe, dqs);
  modport ctrl (output ck, rst_pin_n, cs_n, rcw_n, ba, addr, host_dq_o, host_dq_oe,
                input dq, dqs);
endinterface : cpr_if

`default_nettype wire

// File: hw/cpr_dram_end.sv
`timescale 1ns/1ps
`default_nettype none
`include "cpr_cfg.svh"

// How it works
// - controller enables mode via third register, A2=1
// - controller enables only with all banks idle
// - reads in mode come from pattern register
// - location field selects read operation
// - only reads until mode cleared by A2=0
// - autoprecharge read acts as plain read
// - no power-down, self refresh, non-reads
// - reset pin still works in mode
// - mode off: array reads and writes
// - one-bit pattern over all data pins
// - pin 0 carries bit; others copy or zero
// - controller drives column bits 1:0 as 00
// - full burst: A2 zero, order 0..7
// - chopped burst: A2 picks lower/upper nibble
// - bank and other column bits ignored
// - A12 selects chop on the fly
// - normal read latency and timing apply
// - controller waits for DLL lock first
// - beat 0 is LSB, beat 7 MSB
// - location 00 returns 0,1,0,1 pattern
// - other locations reserved, same ordering
module cpr_dram_end
  import cpr_pkg::*;
#(
  parameter int COL_W        = 6,
  parameter int RL           = `CPR_READ_LAT,
  parameter int WL           = `CPR_WRITE_LAT,
  parameter bit DQ_REPLICATE = 1'b1
) (
  input  wire logic clock,
  input  wire logic rst_n,
  cpr_if.dram       link
);

  // ==========================================================
  // pin synchronisers
  localparam int CW = 22;

  logic [CW-1:0] cmd_s1_r;
  logic [CW-1:0] cmd_s2_r;
  logic [2:0]    ck_sync_r;
  logic [7:0]    dq_s1_r;
  logic [7:0]    dq_s2_r;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cmd_s1_r  <= '0;
      cmd_s2_r  <= '0;
      ck_sync_r <= 3'h0;
      dq_s1_r   <= 8'h00;
      dq_s2_r   <= 8'h00;
    end else begin
      cmd_s1_r  <= {link.rst_pin_n, link.cs_n, link.rcw_n, link.ba, link.addr};
      cmd_s2_r  <= cmd_s1_r;
      ck_sync_r <= {ck_sync_r[1:0], link.ck};
      dq_s1_r   <= link.dq;
      dq_s2_r   <= dq_s1_r;
    end
  end

  // ==========================================================
  // decode
  wire          pin_rst  = ~cmd_s2_r[21];
  wire          ck_rise  = ck_sync_r[1] & ~ck_sync_r[2];
  wire          ck_edge  = ck_sync_r[1] ^ ck_sync_r[2];
  wire  [2:0]   c_ba     = cmd_s2_r[16:14];
  wire  [13:0]  c_addr   = cmd_s2_r[13:0];
  wire cpr_op_t c_op     = cpr_decode(cmd_s2_r[20], cmd_s2_r[19:17]);

  cpr_dev_st_t      st_r;
  logic             mode_en_r;
  logic [1:0]       loc_r;
  logic [1:0]       bl_mode_r;
  logic [3:0]       lat_r;
  logic [2:0]       beat_r;
  logic [2:0]       last_r;
  logic             wr_r;
  logic             pat_rd_r;
  logic [COL_W-4:0] col_r;
  logic [7:0]       dq_r;
  logic             oe_r;
  logic             dqs_r;
  logic [7:0]       mem [0:(2**COL_W)-1];

  wire idle_cmd = ck_rise & (st_r == CPR_D_IDLE);
  wire is_mrs   = idle_cmd & (c_op == CPR_OP_MRS);
  wire is_rd    = idle_cmd & (c_op == CPR_OP_RD);
  // writes are dropped while the pattern mode is on
  wire is_wr    = idle_cmd & (c_op == CPR_OP_WR) & ~mode_en_r;

  // A12 low selects the chopped burst when on-the-fly is set
  wire chop     = (bl_mode_r == `CPR_BL_FIXED4) |
                  ((bl_mode_r == `CPR_BL_OTF) & ~c_addr[`CPR_CHOP_BIT]);
  // only A2 picks the start nibble; A[1:0], A10, A11, A13, bank are unused
  wire [2:0] start  = chop ? {c_addr[2], 2'h0} : 3'h0;
  wire [2:0] last_n = chop ? (start + 3'h3) : 3'h7;

  // ==========================================================
  // read data
  wire       lat_done = ck_rise & (st_r == CPR_D_LAT) & (lat_r == 4'h1);
  wire       in_burst = ck_edge & (st_r == CPR_D_BURST);
  wire [2:0] beat_sel = (st_r == CPR_D_LAT) ? beat_r : (beat_r + 3'h1);
  // reserved locations keep the ordering and read as all zeros
  wire [7:0] pat_word = (loc_r == 2'h0) ? `CPR_PATTERN_LOC0 :
                        `CPR_PATTERN_RSVD;
  wire       pat_bit  = pat_word[beat_sel];
  wire [6:0] upper    = DQ_REPLICATE ? {7{pat_bit}} : 7'h00;
  wire [7:0] arr_byte = mem[{col_r, beat_sel}];
  wire [7:0] rd_byte  = pat_rd_r ? {upper, pat_bit} : arr_byte;
  wire       rd_step  = ~wr_r & (lat_done | (in_burst & (beat_r != last_r)));
  wire       rd_end   = ~wr_r & in_burst & (beat_r == last_r);

  // ==========================================================
  // mode register fields
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode_en_r <= 1'b0;
      loc_r     <= 2'h0;
      bl_mode_r <= `CPR_BL_FIXED8;
    end else if (pin_rst) begin
      mode_en_r <= 1'b0;
      loc_r     <= 2'h0;
      bl_mode_r <= `CPR_BL_FIXED8;
    end else if (is_mrs && c_ba == `CPR_MR_SEL_THREE) begin
      mode_en_r <= c_addr[`CPR_MR3_EN_BIT];
      loc_r     <= c_addr[1:0];
    end else if (is_mrs && c_ba == `CPR_MR_SEL_ZERO) begin
      bl_mode_r <= c_addr[1:0];
    end
  end

  // ==========================================================
  // burst sequencer
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r     <= CPR_D_IDLE;
      lat_r    <= 4'h0;
      beat_r   <= 3'h0;
      last_r   <= 3'h0;
      wr_r     <= 1'b0;
      pat_rd_r <= 1'b0;
      col_r    <= '0;
    end else if (pin_rst) begin
      st_r     <= CPR_D_IDLE;
    end else begin
      case (st_r)
        CPR_D_IDLE: begin
          if (is_rd || is_wr) begin
            st_r     <= CPR_D_LAT;
            lat_r    <= is_rd ? 4'(RL) : 4'(WL);
            beat_r   <= is_rd ? start : 3'h0;
            last_r   <= is_rd ? last_n : 3'h7;
            wr_r     <= is_wr;
            pat_rd_r <= is_rd & mode_en_r;
            col_r    <= c_addr[COL_W-1:3];
          end
        end
        CPR_D_LAT: begin
          if (ck_rise) begin
            lat_r <= lat_r - 4'h1;
            if (lat_r == 4'h1) begin
              st_r <= CPR_D_BURST;
            end
          end
        end
        CPR_D_BURST: begin
          if (in_burst) begin
            if (beat_r == last_r) begin
              st_r <= CPR_D_IDLE;
            end else begin
              beat_r <= beat_r + 3'h1;
            end
          end
        end
        default: st_r <= CPR_D_IDLE;
      endcase
    end
  end

  // ==========================================================
  // data pins and strobe
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dq_r  <= 8'h00;
      oe_r  <= 1'b0;
      dqs_r <= 1'b0;
    end else if (pin_rst || rd_end) begin
      oe_r  <= 1'b0;
      dqs_r <= 1'b0;
    end else if (rd_step) begin
      dq_r  <= rd_byte;
      oe_r  <= 1'b1;
      dqs_r <= ~dqs_r;
    end
  end

  // array is not reset; captured beats land in order 0..7
  always_ff @(posedge clock) begin
    if (wr_r && in_burst && !pin_rst) begin
      mem[{col_r, beat_r}] <= dq_s2_r;
    end
  end

  assign link.dev_dq_o  = dq_r;
  assign link.dev_dq_oe = oe_r;
  assign link.dqs       = dqs_r;

endmodule : cpr_dram_end

`default_nettype wire

// File: hw/cpr_dummy_never.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// File: tb/cpr_chk.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// link checker
module cpr_chk (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        ck,
  input wire logic        rst_pin_n,
  input wire logic        cs_n,
  input wire logic [2:0]  rcw_n,
  input wire logic [2:0]  ba,
  input wire logic [13:0] addr,
  input wire logic        dqs,
  input wire logic [7:0]  dev_dq_o,
  input wire logic        dev_dq_oe,
  input wire logic        host_dq_oe
);
  localparam int LAT_LO = 96;
  localparam int LAT_HI = 112;

  logic       ck_d_r;
  logic       mode_r;
  logic [1:0] loc_r;
  wire        ck_rise  = ck && !ck_d_r;
  wire        mrs3     = ck_rise && !cs_n && rcw_n == 3'h0 && ba == 3'h3;
  wire        rd_cmd   = ck_rise && !cs_n && rcw_n == 3'h5;
  wire        mode_nxt = !rst_pin_n ? 1'b0 : (mrs3 ? addr[2] : mode_r);
  wire [1:0]  loc_nxt  = !rst_pin_n ? 2'h0 : (mrs3 ? addr[1:0] : loc_r);
  logic [1:0] bl_r;
  wire        mrs0     = ck_rise && !cs_n && rcw_n == 3'h0 && ba == 3'h0;
  wire [1:0]  bl_nxt   = !rst_pin_n ? 2'h0 : (mrs0 ? addr[1:0] : bl_r);
  // full burst: fixed eight, or on-the-fly with A12 high
  wire        full_rd  = rd_cmd && (bl_r == 2'h0 || (bl_r == 2'h1 && addr[12]));

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ck_d_r <= 1'b0;
      mode_r <= 1'b0;
      loc_r  <= 2'h0;
      bl_r   <= 2'h0;
    end else begin
      ck_d_r <= ck;
      mode_r <= mode_nxt;
      loc_r  <= loc_nxt;
      bl_r   <= bl_nxt;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  // ==========================================================
  // assertions
  a_lane_pattern: assert property (mode_r && dev_dq_oe |->
    dev_dq_o inside {8'h00, 8'hFF})
    else $error("pattern lanes differ");
  a_rsvd_zero: assert property (mode_r && loc_r != 2'h0 && dev_dq_oe |->
    dev_dq_o == 8'h00)
    else $error("reserved location not zero");
  a_first_beat: assert property (mode_r && $rose(dev_dq_oe) |->
    dev_dq_o == 8'h00 && dqs)
    else $error("first pattern beat wrong");
  a_beats_alternate: assert property (mode_r && loc_r == 2'h0 && dev_dq_oe
    && $past(dev_dq_oe) && dqs != $past(dqs) |-> dev_dq_o == ~$past(dev_dq_o))
    else $error("pattern beats do not alternate");
  a_no_write_mode: assert property (mode_r |-> !host_dq_oe)
    else $error("write data driven in pattern mode");
  a_rd_low_bits: assert property (rd_cmd && mode_r |-> addr[1:0] == 2'h0)
    else $error("pattern read low column bits set");
  a_full_a2_zero: assert property (full_rd && mode_r |-> !addr[2])
    else $error("full pattern read with A2 set");
  a_read_latency: assert property (rd_cmd |-> ##[LAT_LO:LAT_HI] $rose(dev_dq_oe))
    else $error("read data latency wrong");
  a_reset_abort: assert property ($fell(rst_pin_n) |-> ##[1:6] (!dev_dq_oe && !dqs))
    else $error("reset pin did not stop burst");

  c_pat_read: cover property (rd_cmd && mode_r);
  c_rsvd_read: cover property (mode_r && loc_r != 2'h0 && $rose(dev_dq_oe));
  c_pin_reset: cover property (mode_r && $fell(rst_pin_n));
endmodule : cpr_chk

`default_nettype wire

// File: tb/dram_calibration_pattern_readout_tb.sv
`timescale 1ns/1ps
`default_nettype none

module dram_calibration_pattern_readout_tb
  import cpr_pkg::*;
;
  logic        clock          = 1'b0;
  logic        rst_n          = 1'b0;
  logic        dram_reset_req = 1'b0;
  logic        cmd_valid      = 1'b0;
  logic        rd_ready       = 1'b0;
  logic        stall          = 1'b0;
  cpr_op_t     cmd_op         = CPR_OP_NOP;
  logic [2:0]  cmd_ba         = 3'h0;
  logic [13:0] cmd_addr       = 14'h0000;
  logic [63:0] cmd_wdata      = 64'h0000_0000_0000_0000;
  logic        cmd_ready;
  logic        cmd_refused;
  logic        pattern_mode;
  logic        rd_valid;
  logic [7:0]  rd_data;
  logic [7:0]  exp_q[$];
  logic [13:0] wa;
  int          err_count      = 0;
  int          total_checks   = 0;
  int          cycles         = 0;
  int          seed           = 86;

  always #4 clock = ~clock;

  cpr_if i_cpr_if ();
  cpr_dram_end #(.DQ_REPLICATE(1'b1)) i_cpr_dram_end (.clock, .rst_n, .link(i_cpr_if));
  cpr_ctrl_end #(.DLL_WAIT_NCK(4), .GAP_NCK(12)) i_cpr_ctrl_end (.clock, .rst_n,
    .dram_reset_req, .cmd_valid, .cmd_ready, .cmd_op, .cmd_ba, .cmd_addr, .cmd_wdata,
    .cmd_refused, .pattern_mode, .rd_valid, .rd_ready, .rd_data, .link(i_cpr_if));
  cpr_chk i_cpr_chk (.clock, .rst_n, .ck(i_cpr_if.ck), .rst_pin_n(i_cpr_if.rst_pin_n),
    .cs_n(i_cpr_if.cs_n), .rcw_n(i_cpr_if.rcw_n), .ba(i_cpr_if.ba), .addr(i_cpr_if.addr),
    .dqs(i_cpr_if.dqs), .dev_dq_o(i_cpr_if.dev_dq_o), .dev_dq_oe(i_cpr_if.dev_dq_oe),
    .host_dq_oe(i_cpr_if.host_dq_oe));

  // ==========================================================
  // checking and closing
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish

  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      err_count++;
      tally_and_finish();
    end
  end

  // read port: random stalls, compare each byte popped
  always @(negedge clock) begin
    logic nr;
    nr = !stall && (($random(seed) & 3) != 0);
    if (rd_valid === 1'b1 && nr) begin
      chk(rd_data, exp_q.size() ? exp_q.pop_front() : 8'hxx);
    end
    rd_ready = nr;
  end

  // ==========================================================
  // command driving
  task automatic op(input cpr_op_t o, input logic [2:0] b, input logic [13:0] a,
                    input logic ref_exp);
    int n;
    n = 0;
    @(negedge clock);
    cmd_valid = 1'b1;
    cmd_op    = o;
    cmd_ba    = b;
    cmd_addr  = a;
    while (n < 4000) begin
      #1;
      if (cmd_ready === 1'b1) break;
      @(negedge clock);
      n++;
    end
    chk(cmd_ready, 1'b1);
    chk(cmd_refused, ref_exp);
    @(posedge clock);
    @(negedge clock);
    cmd_valid = 1'b0;
  endtask : op

  task automatic rd_arr();
    for (int i = 0; i < 8; i++) exp_q.push_back(cmd_wdata[8*i +: 8]);
    op(CPR_OP_RD, 3'h0, wa, 1'b0);
  endtask : rd_arr

  task automatic wr_rd();
    @(negedge clock);
    cmd_wdata = {$random(seed), $random(seed)};
    wa = (14'($random(seed)) & 14'h0038) | 14'h1000;
    op(CPR_OP_WR, 3'h0, wa, 1'b0);
    rd_arr();
  endtask : wr_rd

  task automatic prd(input logic [1:0] loc, input logic a12, input logic a2);
    logic [13:0] a;
    a = (14'($random(seed)) & (a12 ? 14'h2FFF : 14'h2FFB)) | {1'b0, a12, 9'h000, a2, 2'b00};
    for (int i = 0; i < 8; i++) begin
      if (a12 || i[2] == a2) exp_q.push_back((loc == 2'h0 && i[0]) ? 8'hFF : 8'h00);
    end
    op(CPR_OP_RD, 3'($random(seed)), a, 1'b0);
  endtask : prd

  // ==========================================================
  // main sequence
  initial begin
    repeat (3) @(posedge clock);
    @(negedge clock);
    rst_n = 1'b1;
    op(CPR_OP_MRS, 3'h0, 14'h0001, 1'b0);
    wr_rd();
    for (int loc = 0; loc < 4; loc++) begin
      op(CPR_OP_MRS, 3'h3, 14'(4 + loc), 1'b0);
      repeat (2) @(negedge clock);
      chk(pattern_mode, 1'b1);
      prd(loc[1:0], 1'b1, 1'b0);
      prd(loc[1:0], 1'b0, 1'b0);
      prd(loc[1:0], 1'b0, 1'b1);
      op(CPR_OP_WR, 3'h0, 14'h0000, 1'b1);
    end
    op(CPR_OP_MRS, 3'h3, 14'h0000, 1'b0);
    repeat (2) @(negedge clock);
    chk(pattern_mode, 1'b0);
    wr_rd();
    op(CPR_OP_MRS, 3'h0, 14'h0002, 1'b0);
    op(CPR_OP_MRS, 3'h3, 14'h0004, 1'b0);
    prd(2'h0, 1'b0, 1'b1);
    repeat (200) @(negedge clock);
    chk(pattern_mode, 1'b1);
    dram_reset_req = 1'b1;
    repeat (20) @(negedge clock);
    chk(pattern_mode, 1'b0);
    dram_reset_req = 1'b0;
    wr_rd();
    @(posedge clock);
    stall = 1'b1;
    rd_arr();
    repeat (300) @(negedge clock);
    chk(rd_valid, 1'b1);
    @(posedge clock);
    stall = 1'b0;
    for (int n = 0; n < 3000 && exp_q.size() != 0; n++) @(negedge clock);
    chk(exp_q.size(), 0);
    tally_and_finish();
  end
endmodule : dram_calibration_pattern_readout_tb

`default_nettype wire
